// ### rtl/rod_block_interlock.sv
// Rod withdrawal interlock with two redundant block circuits, gang selection and an APB register file.
// Overview of operation
// - Shutdown mode blocks every rod withdrawal unconditionally.
// - Rod pattern violation blocks withdrawal in every mode.
// - Substitute position violation, alone or between channels, blocks in every mode.
// - Run, startup or refuel: power range upscale alarm blocks.
// - Run, startup or refuel: power range inoperative alarm blocks.
// - Run only: power range downscale or flow reference upscale blocks.
// - Run, startup or refuel: discharge volume high level blocks.
// - Startup/refuel: source detector withdrawn, count low, intermediate on low range blocks.
// - Startup/refuel: source range upscale alarm blocks.
// - Startup/refuel: source range downscale alarm blocks.
// - Startup/refuel: source range inoperative alarm blocks.
// - Startup/refuel: intermediate detector not fully inserted blocks.
// - Startup/refuel: intermediate range upscale alarm blocks.
// - Startup/refuel: intermediate downscale blocks unless that monitor is on lowest range.
// - Startup/refuel: intermediate range inoperative alarm blocks.
// - Startup/refuel: refueling platform over core blocks.
// - Refuel only: grapple loaded blocks.
// - Refuel only: bypassed discharge volume scram trip blocks.
// - Gang mode: selecting one rod selects its whole gang of one to sixteen.
// - Gang moves in notch or continuous mode like one rod, pattern blocks apply.
// - In the density/power band, gang misalignment across notches blocks gang withdrawal.
// - Two circuits each see half the monitors; discharge volume signals feed both.
// - Block when either circuit trips; permit withdrawal only when both agree.
// - A block during withdrawal stops the rod at the next notch.
`timescale 1ns/1ns
`include "rod_block_map.svh"

module rod_block_interlock (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Plant mode and plant-wide conditions.
  input wire rod_block_pkg::plant_mode_t plant_mode,
  input wire logic pattern_violation,
  input wire logic substitute_position_violation,
  input wire logic substitute_position_channel_violation,
  input wire logic discharge_volume_high_level,
  input wire logic discharge_volume_trip_bypassed,
  input wire logic platform_over_core,
  input wire logic grapple_loaded,
  // Source range monitor channels.
  input wire logic [`SOURCE_RANGE_MONITOR_N-1:0] source_range_monitor_upscale,
  input wire logic [`SOURCE_RANGE_MONITOR_N-1:0] source_range_monitor_downscale,
  input wire logic [`SOURCE_RANGE_MONITOR_N-1:0] source_range_monitor_inop,
  input wire logic [`SOURCE_RANGE_MONITOR_N-1:0] source_range_monitor_not_inserted,
  input wire logic [`SOURCE_RANGE_MONITOR_N-1:0] source_range_monitor_below_permit,
  // Intermediate range monitor channels.
  input wire logic [`INTERMEDIATE_RANGE_MONITOR_N-1:0] intermediate_range_monitor_upscale,
  input wire logic [`INTERMEDIATE_RANGE_MONITOR_N-1:0] intermediate_range_monitor_downscale,
  input wire logic [`INTERMEDIATE_RANGE_MONITOR_N-1:0] intermediate_range_monitor_inop,
  input wire logic [`INTERMEDIATE_RANGE_MONITOR_N-1:0] intermediate_range_monitor_not_inserted,
  input wire logic [`INTERMEDIATE_RANGE_MONITOR_N-1:0] intermediate_range_monitor_lowest_range,
  input wire logic [`INTERMEDIATE_RANGE_MONITOR_N-1:0] intermediate_range_monitor_two_lowest,
  // Power range monitor channels.
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_upscale,
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_inop,
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_downscale,
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_flow_ref_upscale,
  // Rod selection, positions and gang band.
  input wire logic rod_select_valid,
  input wire logic [`ROD_IDX_W-1:0] rod_select_idx,
  input wire rod_block_pkg::notch_t [`ROD_N-1:0] rod_notch,
  input wire logic gang_band_active,
  // Operator motion requests and drive feedback.
  input wire logic insert_req,
  input wire logic withdraw_req,
  input wire logic cont_withdraw_req,
  input wire logic notch_reached,
  // Commands to the rod drive logic and indications.
  output logic withdraw_cmd,
  output logic insert_cmd,
  output logic [`ROD_N-1:0] rod_selected,
  output logic rod_block,
  output logic circuit_mismatch
);
  import rod_block_pkg::*;

  localparam int SRC_N = `SOURCE_RANGE_MONITOR_N;
  localparam int INT_N = `INTERMEDIATE_RANGE_MONITOR_N;
  localparam int PWR_N = `POWER_RANGE_MONITOR_N;

  // Reduces the channels that belong to one circuit: even channels to circuit 0, odd to circuit 1.
  function automatic logic half_any(input logic [15:0] vec, input int n, input int circ);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i < n && (i % 2) == circ) begin
        r = r | vec[i];
      end
    end
    return r;
  endfunction

  // Matches an APB access to a register offset.
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] offs);
    return addr == offs;
  endfunction

  logic [31:0] ctrl_r;
  logic [`GANG_ID_W-1:0] gang_id_r [`ROD_N];

  logic [1:0] circuit_trip;
  logic [`CAUSE_W-1:0] cause_nxt;
  logic [`CAUSE_W-1:0] cause_r;

  logic block_a_r;
  logic block_b_r;
  logic gang_misalign;
  logic gang_misalign_r;

  logic block_now;
  logic moving;
  withdraw_state_t wd_state_r;

  // Mode groups used by the block rules.

  logic mode_rsr;
  logic mode_sr;
  logic mode_run;
  logic mode_refuel;
  assign mode_rsr = plant_mode != MODE_SHUTDOWN;
  assign mode_sr = plant_mode == MODE_STARTUP || plant_mode == MODE_REFUEL;
  assign mode_run = plant_mode == MODE_RUN;
  assign mode_refuel = plant_mode == MODE_REFUEL;

  // Each circuit evaluates the plant-wide conditions and its own half of the monitors.
  for (genvar c = 0; c < 2; c++) begin : g_circuit
    logic pwr_trip;
    logic run_trip;
    logic low_trip;
    logic retract_trip;
    logic refuel_trip;
    logic wide_trip;

    // These block in every mode, shutdown included.
    assign wide_trip = plant_mode == MODE_SHUTDOWN
      || pattern_violation
      || substitute_position_violation || substitute_position_channel_violation;

    assign pwr_trip = mode_rsr && (half_any(16'(power_range_monitor_upscale), PWR_N, c)
      || half_any(16'(power_range_monitor_inop), PWR_N, c)
      || discharge_volume_high_level);
    assign run_trip = mode_run && (half_any(16'(power_range_monitor_downscale), PWR_N, c)
      || half_any(16'(power_range_monitor_flow_ref_upscale), PWR_N, c));

    // Low flux blocks apply in startup and refuel only.
    assign retract_trip = half_any(16'(source_range_monitor_not_inserted & source_range_monitor_below_permit),
      SRC_N, c) && half_any(16'(intermediate_range_monitor_two_lowest), INT_N, c);
    assign low_trip = mode_sr && (retract_trip
      || half_any(16'(source_range_monitor_upscale), SRC_N, c)
      || half_any(16'(source_range_monitor_downscale), SRC_N, c)
      || half_any(16'(source_range_monitor_inop), SRC_N, c)
      || half_any(16'(intermediate_range_monitor_not_inserted), INT_N, c)
      || half_any(16'(intermediate_range_monitor_upscale), INT_N, c)
      || half_any(16'(intermediate_range_monitor_downscale & ~intermediate_range_monitor_lowest_range),
        INT_N, c)
      || half_any(16'(intermediate_range_monitor_inop), INT_N, c)
      || platform_over_core);

    assign refuel_trip = mode_refuel && (grapple_loaded
      || discharge_volume_trip_bypassed);
    assign circuit_trip[c] = wide_trip || pwr_trip || run_trip || low_trip || refuel_trip;
  end

  // Gang misalignment: the selected rods do not all stand on the same notch.
  always_comb begin
    notch_t lo;
    notch_t hi;
    lo = '1;
    hi = '0;

    for (int i = 0; i < `ROD_N; i++) begin
      if (rod_selected[i]) begin
        if (rod_notch[i] < lo) begin
          lo = rod_notch[i];
        end
        if (rod_notch[i] > hi) begin
          hi = rod_notch[i];
        end
      end
    end

    gang_misalign = ctrl_r[`CTRL_GANG_ENABLE] && gang_band_active && (hi > lo);
  end

  // Cause bits merge both circuits.
  always_comb begin
    cause_nxt = '0;
    cause_nxt[`CAUSE_SHUTDOWN] = plant_mode == MODE_SHUTDOWN;
    cause_nxt[`CAUSE_PATTERN] = pattern_violation;
    cause_nxt[`CAUSE_POSITION] = substitute_position_violation || substitute_position_channel_violation;
    cause_nxt[`CAUSE_POWER_RANGE] = (mode_rsr && (|power_range_monitor_upscale || |power_range_monitor_inop))
      || (mode_run && (|power_range_monitor_downscale || |power_range_monitor_flow_ref_upscale));
    cause_nxt[`CAUSE_DISCHARGE] = mode_rsr && discharge_volume_high_level;
    cause_nxt[`CAUSE_LOW_RANGE] = mode_sr && (g_circuit[0].low_trip || g_circuit[1].low_trip);
    cause_nxt[`CAUSE_REFUEL] = mode_refuel && (grapple_loaded || discharge_volume_trip_bypassed);
    cause_nxt[`CAUSE_GANG] = gang_misalign;
  end

  // Registered circuit outputs; the combined block is what gates withdrawal.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_a_r <= 1'b1;
      block_b_r <= 1'b1;
      gang_misalign_r <= 1'b0;
      cause_r <= '0;
    end else begin
      block_a_r <= circuit_trip[0];
      block_b_r <= circuit_trip[1];
      gang_misalign_r <= gang_misalign;
      cause_r <= cause_nxt;
    end
  end

  // Blocks are held from reset until both circuits have reported, so nothing moves on stale state.
  assign block_now = block_a_r || block_b_r || (block_a_r != block_b_r) || gang_misalign_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rod_block <= 1'b1;
      circuit_mismatch <= 1'b0;
    end else begin
      rod_block <= circuit_trip[0] || circuit_trip[1] || gang_misalign;
      circuit_mismatch <= circuit_trip[0] != circuit_trip[1];
    end
  end

  assign moving = wd_state_r == WD_MOVING || insert_cmd;

  // Withdraw sequencing: a started notch always completes, so a block stops the rod at the next notch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_state_r <= WD_IDLE;
      withdraw_cmd <= 1'b0;
    end else begin
      case (wd_state_r)
        WD_IDLE: begin
          if (withdraw_req && !insert_req && !block_now && |rod_selected) begin
            wd_state_r <= WD_MOVING;
            withdraw_cmd <= 1'b1;
          end
        end
        WD_MOVING: begin
          // Both buttons held re-arm the next notch unless blocked.
          if (notch_reached) begin
            if (withdraw_req && cont_withdraw_req && !block_now) begin
              wd_state_r <= WD_MOVING;
            end else begin
              wd_state_r <= WD_IDLE;
              withdraw_cmd <= 1'b0;
            end
          end
        end
        default: begin
          wd_state_r <= WD_IDLE;
          withdraw_cmd <= 1'b0;
        end
      endcase
    end
  end

  // Insert passes through the interlock untouched; it needs a selected rod and a running withdraw holds it off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insert_cmd <= 1'b0;
    end else begin
      insert_cmd <= insert_req && wd_state_r == WD_IDLE && |rod_selected;
    end
  end

  // Rod and gang selection; it is frozen while any rod is moving.
  // A deselect therefore waits for the moving rod.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rod_selected <= '0;
    end else if (!moving) begin
      if (rod_select_valid) begin
        for (int i = 0; i < `ROD_N; i++) begin
          if (ctrl_r[`CTRL_GANG_ENABLE]) begin
            rod_selected[i] <= gang_id_r[i] == gang_id_r[rod_select_idx];
          end else begin
            rod_selected[i] <= i == int'(rod_select_idx);
          end
        end
      end else if (ctrl_r[`CTRL_DESELECT]) begin
        rod_selected <= '0;
      end
    end
  end

  // APB slave: one wait-free access phase, pready raised for the access cycle only.
  logic setup;
  logic access;
  logic mapped;
  logic gang_hit;
  logic [`ROD_IDX_W-1:0] gang_idx;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign gang_hit = paddr >= `REG_GANG_BASE && paddr <= `REG_GANG_LAST && paddr[1:0] == 2'b00;
  assign gang_idx = paddr[`ROD_IDX_W+1:2];
  assign mapped = hit(paddr, `REG_CTRL) || hit(paddr, `REG_STATUS) || hit(paddr, `REG_CAUSE)
    || hit(paddr, `REG_SELECT) || gang_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;

      // Read data is taken at the setup edge and stands through the access cycle.
      if (setup && !pwrite) begin
        prdata <= 32'h0000_0000;
        if (hit(paddr, `REG_CTRL)) begin
          prdata <= ctrl_r;
        end else if (hit(paddr, `REG_STATUS)) begin
          prdata[`ST_BLOCK] <= rod_block;
          prdata[`ST_BLOCK_A] <= block_a_r;
          prdata[`ST_BLOCK_B] <= block_b_r;
          prdata[`ST_MISMATCH] <= circuit_mismatch;
          prdata[`ST_WITHDRAW] <= withdraw_cmd;
          prdata[`ST_INSERT] <= insert_cmd;
          prdata[`ST_GANG_MISALIGN] <= gang_misalign_r;
        end else if (hit(paddr, `REG_CAUSE)) begin
          prdata[`CAUSE_W-1:0] <= cause_r;
        end else if (hit(paddr, `REG_SELECT)) begin
          prdata[`ROD_N-1:0] <= rod_selected;
        end else if (gang_hit) begin
          prdata[`GANG_ID_W-1:0] <= gang_id_r[gang_idx];
        end
      end else if (access) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Control register; deselect is a self-clearing request bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (access && pwrite && hit(paddr, `REG_CTRL)) begin
      ctrl_r <= {30'h0000_0000, pwdata[`CTRL_DESELECT], pwdata[`CTRL_GANG_ENABLE]};
    end else begin
      ctrl_r[`CTRL_DESELECT] <= ctrl_r[`CTRL_DESELECT] && moving;
    end
  end

  // Gang membership table: each rod is placed in a gang by number.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ROD_N; i++) begin
        gang_id_r[i] <= `GANG_ID_W'(i);
      end
    end else if (access && pwrite && gang_hit) begin
      gang_id_r[gang_idx] <= pwdata[`GANG_ID_W-1:0];
    end
  end
endmodule

// ### rtl/rod_block_map.svh
// Register offsets, field positions, sizes and reset values of the rod block interlock.
`ifndef ROD_BLOCK_MAP_SVH
`define ROD_BLOCK_MAP_SVH

// Channel and rod counts.
`define SOURCE_RANGE_MONITOR_N 4
`define INTERMEDIATE_RANGE_MONITOR_N 8
`define POWER_RANGE_MONITOR_N 6
`define ROD_N 16
`define ROD_IDX_W 4
`define GANG_ID_W 4
`define NOTCH_W 6

// Register byte offsets.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_CAUSE 12'h008
`define REG_SELECT 12'h00c
`define REG_GANG_BASE 12'h040
`define REG_GANG_LAST 12'h07c

// Control register fields.
`define CTRL_GANG_ENABLE 0
`define CTRL_DESELECT 1
`define CTRL_RESET 32'h0000_0000

// Status register fields.
`define ST_BLOCK 0
`define ST_BLOCK_A 1
`define ST_BLOCK_B 2
`define ST_MISMATCH 3
`define ST_WITHDRAW 4
`define ST_INSERT 5
`define ST_GANG_MISALIGN 6

// Cause register fields.
`define CAUSE_W 8
`define CAUSE_SHUTDOWN 0
`define CAUSE_PATTERN 1
`define CAUSE_POSITION 2
`define CAUSE_POWER_RANGE 3
`define CAUSE_DISCHARGE 4
`define CAUSE_LOW_RANGE 5
`define CAUSE_REFUEL 6
`define CAUSE_GANG 7

`endif

// ### rtl/rod_block_pkg.sv
// Types shared by the rod block interlock.
package rod_block_pkg;
  typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_REFUEL, MODE_STARTUP, MODE_RUN} plant_mode_t;
  typedef enum logic {WD_IDLE, WD_MOVING} withdraw_state_t;
  typedef logic [5:0] notch_t;
endpackage

// ### tb/rod_block_interlock_sva.sv
// Concurrent checks on the ports of the rod block interlock.
`timescale 1ns/1ns
`include "rod_block_map.svh"
module rod_block_interlock_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Watched inputs.
  input wire rod_block_pkg::plant_mode_t plant_mode,
  input wire logic pattern_violation,
  input wire logic substitute_position_violation,
  input wire logic substitute_position_channel_violation,
  input wire logic discharge_volume_high_level,
  input wire logic grapple_loaded,
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_upscale,
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_downscale,
  input wire logic [`POWER_RANGE_MONITOR_N-1:0] power_range_monitor_flow_ref_upscale,
  input wire logic insert_req,
  input wire logic notch_reached,
  // Watched outputs.
  input wire logic withdraw_cmd,
  input wire logic insert_cmd,
  input wire logic [`ROD_N-1:0] rod_selected,
  input wire logic rod_block,
  input wire logic circuit_mismatch
);
  import rod_block_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SHUTDOWN_BLOCK: assert property (plant_mode == MODE_SHUTDOWN |=> rod_block)
    else $error("no block in shutdown");
  AST_PATTERN_BLOCK: assert property (pattern_violation |=> rod_block)
    else $error("no block on pattern violation");
  AST_POSITION_BLOCK: assert property ((substitute_position_violation
    || substitute_position_channel_violation) |=> rod_block)
    else $error("no block on position violation");
  AST_POWER_UPSCALE: assert property ((|power_range_monitor_upscale) |=> rod_block)
    else $error("no block on power range upscale");
  AST_RUN_ONLY: assert property (plant_mode == MODE_RUN
    && (|(power_range_monitor_downscale | power_range_monitor_flow_ref_upscale)) |=> rod_block)
    else $error("no block on downscale in run");
  AST_DISCHARGE: assert property (discharge_volume_high_level |=> rod_block)
    else $error("no block on discharge volume level");
  AST_GRAPPLE: assert property (plant_mode == MODE_REFUEL && grapple_loaded |=> rod_block)
    else $error("no block on grapple loaded");
  AST_MISMATCH_BLOCKS: assert property (circuit_mismatch |-> rod_block)
    else $error("mismatch without block");
  AST_HOLD_TO_NOTCH: assert property (withdraw_cmd && !notch_reached |=> withdraw_cmd)
    else $error("withdraw dropped between notches");
  AST_STOP_AT_NOTCH: assert property (withdraw_cmd && notch_reached && rod_block |=> !withdraw_cmd)
    else $error("withdraw ran past notch under block");
  AST_NO_START_BLOCKED: assert property ($rose(withdraw_cmd) |-> !$past(rod_block) && !$past(insert_req))
    else $error("withdraw started while blocked");
  AST_INSERT_FREE: assert property (insert_req && !withdraw_cmd && (|rod_selected) |=> insert_cmd)
    else $error("insert suppressed");
endmodule

bind rod_block_interlock rod_block_interlock_chk chk_i (.pclk, .presetn, .plant_mode, .pattern_violation,
  .substitute_position_violation, .substitute_position_channel_violation, .discharge_volume_high_level,
  .grapple_loaded, .power_range_monitor_upscale, .power_range_monitor_downscale,
  .power_range_monitor_flow_ref_upscale, .insert_req, .notch_reached, .withdraw_cmd, .insert_cmd,
  .rod_selected, .rod_block, .circuit_mismatch);

// ### tb/rod_drive_model.sv
// Behavioural rod drive that reports each notch reached while a withdraw command stands.
`timescale 1ns/1ns
module rod_drive_model #(
  parameter int NOTCH_CYCLES = 5
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Drive command and feedback.
  input wire logic withdraw_cmd,
  output logic notch_reached
);
  int cnt;

  // The count restarts whenever the command drops, so a stopped rod never reports a stale notch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      notch_reached <= 1'b0;
    end else if (withdraw_cmd && cnt == NOTCH_CYCLES - 1) begin
      cnt <= 0;
      notch_reached <= 1'b1;
    end else begin
      cnt <= withdraw_cmd ? cnt + 1 : 0;
      notch_reached <= 1'b0;
    end
  end
endmodule

// ### tb/test_rod_block_interlock.sv
// Self-checking bench for the rod block interlock.
`timescale 1ns/1ns
module test_rod_block_interlock;
  import rod_block_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  plant_mode_t plant_mode;
  logic pattern_violation, substitute_position_violation, substitute_position_channel_violation;
  logic discharge_volume_high_level, discharge_volume_trip_bypassed, platform_over_core, grapple_loaded;
  logic [3:0] source_range_monitor_upscale, source_range_monitor_downscale, source_range_monitor_inop;
  logic [3:0] source_range_monitor_not_inserted, source_range_monitor_below_permit;
  logic [7:0] intermediate_range_monitor_upscale, intermediate_range_monitor_downscale;
  logic [7:0] intermediate_range_monitor_inop, intermediate_range_monitor_not_inserted;
  logic [7:0] intermediate_range_monitor_lowest_range, intermediate_range_monitor_two_lowest;
  logic [5:0] power_range_monitor_upscale, power_range_monitor_inop;
  logic [5:0] power_range_monitor_downscale, power_range_monitor_flow_ref_upscale;
  logic rod_select_valid, gang_band_active, insert_req, withdraw_req, cont_withdraw_req, notch_reached;
  logic [3:0] rod_select_idx;
  notch_t [15:0] rod_notch;
  logic withdraw_cmd, insert_cmd, rod_block, circuit_mismatch;
  logic [15:0] rod_selected;
  int n_mismatch, check_count;

  rod_block_interlock DUT (.*);
  rod_drive_model #(.NOTCH_CYCLES(5)) drive (.pclk, .presetn, .withdraw_cmd, .notch_reached);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Every wait is bounded so a stuck handshake ends the run instead of hanging it.
  task automatic wait_for(ref logic sig, input logic v);
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (sig !== v && i < 60);
    if (sig !== v) begin
      n_mismatch++;
      test_done();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_for(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic select_rod(input logic [3:0] idx);
    rod_select_valid <= 1'b1;
    rod_select_idx <= idx;
    cyc(1);
    rod_select_valid <= 1'b0;
    cyc(2);
  endtask

  task automatic set_cause(input int k, input logic v);
    case (k)
      0: pattern_violation <= v;
      1: substitute_position_violation <= v;
      2: substitute_position_channel_violation <= v;
      3: power_range_monitor_upscale[1] <= v;
      4: power_range_monitor_inop[2] <= v;
      5: power_range_monitor_downscale[3] <= v;
      6: power_range_monitor_flow_ref_upscale[4] <= v;
      7: discharge_volume_high_level <= v;
      8: begin
        source_range_monitor_not_inserted[0] <= v;
        source_range_monitor_below_permit[0] <= v;
        intermediate_range_monitor_two_lowest[2] <= v;
      end
      9: source_range_monitor_upscale[1] <= v;
      10: source_range_monitor_downscale[2] <= v;
      11: source_range_monitor_inop[3] <= v;
      12: intermediate_range_monitor_not_inserted[5] <= v;
      13: intermediate_range_monitor_upscale[6] <= v;
      14: intermediate_range_monitor_downscale[7] <= v;
      15: intermediate_range_monitor_inop[0] <= v;
      16: platform_over_core <= v;
      17: grapple_loaded <= v;
      18: discharge_volume_trip_bypassed <= v;
      default: begin
        intermediate_range_monitor_downscale[1] <= v;
        intermediate_range_monitor_lowest_range[1] <= v;
      end
    endcase
  endtask

  function automatic logic exp_block(input plant_mode_t md, input int k);
    if (md == MODE_SHUTDOWN) return 1'b1;
    case (k)
      0, 1, 2, 3, 4, 7: return 1'b1;
      5, 6: return md == MODE_RUN;
      17, 18: return md == MODE_REFUEL;
      19: return 1'b0;
      default: return md == MODE_REFUEL || md == MODE_STARTUP;
    endcase
  endfunction

  task automatic test_causes();
    logic e;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 20; k++) begin
        plant_mode <= plant_mode_t'(m);
        set_cause(k, 1'b1);
        cyc(2);
        e = exp_block(plant_mode_t'(m), k);
        chk(rod_block, e);
        if ((k >= 3 && k <= 6) || (k >= 9 && k <= 15)) chk(circuit_mismatch, m != 0 && e);
        set_cause(k, 1'b0);
        cyc(2);
      end
    end
    $display("test_causes done");
  endtask

  task automatic test_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h05c, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    $display("test_regs done");
  endtask

  task automatic test_circuits();
    plant_mode <= MODE_RUN;
    for (int c = 0; c < 2; c++) begin
      power_range_monitor_upscale <= 6'h01 << c;
      cyc(2);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'h0000_000f, c ? 32'h0000_000d : 32'h0000_000b);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0008);
      power_range_monitor_upscale <= 6'h00;
      cyc(2);
    end
    $display("test_circuits done");
  endtask

  task automatic test_withdraw();
    select_rod(4'h3);
    chk(rod_selected, 16'h0008);
    withdraw_req <= 1'b1;
    cont_withdraw_req <= 1'b1;
    wait_for(withdraw_cmd, 1'b1);
    wait_for(notch_reached, 1'b1);
    cyc(1);
    chk(withdraw_cmd, 1'b1);
    pattern_violation <= 1'b1;
    wait_for(notch_reached, 1'b1);
    cyc(1);
    chk(withdraw_cmd, 1'b0);
    cyc(3);
    chk(withdraw_cmd, 1'b0);
    insert_req <= 1'b1;
    cyc(2);
    chk(insert_cmd, 1'b1);
    {insert_req, withdraw_req, cont_withdraw_req, pattern_violation} <= 4'h0;
    cyc(2);
    $display("test_withdraw done");
  endtask

  task automatic test_gang();
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h054, 32'h4);
    apb(1'b1, 12'h058, 32'h4);
    select_rod(4'h5);
    chk(rod_selected, 16'h0070);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0000_0070);
    gang_band_active <= 1'b1;
    rod_notch[4] <= 6'h01;
    cyc(2);
    chk(rod_block, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[6], 1'b1);
    gang_band_active <= 1'b0;
    cyc(2);
    chk(rod_block, 1'b0);
    rod_notch[4] <= 6'h00;
    apb(1'b1, 12'h000, 32'h2);
    cyc(2);
    chk(rod_selected, 16'h0000);
    $display("test_gang done");
  endtask

  initial begin
    n_mismatch = 0;
    check_count = 0;
    presetn = 1'b0;
    plant_mode = MODE_SHUTDOWN;
    {psel, penable, pwrite, paddr, pwdata, pattern_violation, substitute_position_violation,
      substitute_position_channel_violation, discharge_volume_high_level, discharge_volume_trip_bypassed,
      platform_over_core, grapple_loaded, source_range_monitor_upscale, source_range_monitor_downscale,
      source_range_monitor_inop, source_range_monitor_not_inserted, source_range_monitor_below_permit,
      intermediate_range_monitor_upscale, intermediate_range_monitor_downscale, intermediate_range_monitor_inop,
      intermediate_range_monitor_not_inserted, intermediate_range_monitor_lowest_range,
      intermediate_range_monitor_two_lowest, power_range_monitor_upscale, power_range_monitor_inop,
      power_range_monitor_downscale, power_range_monitor_flow_ref_upscale, rod_select_valid, rod_select_idx,
      rod_notch, gang_band_active, insert_req, withdraw_req, cont_withdraw_req} = '0;
    cyc(10);
    presetn <= 1'b1;
    cyc(2);
    test_regs();
    test_causes();
    test_circuits();
    test_withdraw();
    test_gang();
    test_done();
  end
endmodule
